// [rtl/vcm_defs.svh]
// Constants of the vacuum condition monitor: parameter indices, bits, limits, timing.
// Assumes a 20 MHz system clock; values arrive already digitised on that clock.
// Overview of operation
// [RULE1] Over six valve switchings in 3 s: continuous suction
// [RULE2] That trip raises warning and status bit
// [RULE3] Evacuation over limit: warning, light yellow
// [RULE4] Leakage measured in control mode, readable
// [RULE5] Low leakage: fall to reset, resume quietly
// [RULE6] High leakage: warning, light yellow
// [RULE7] Leakage limit 1..9999; zero disables warning
// [RULE8] Sample dynamic pressure at cycle start
// [RULE9] Dynamic pressure in band: warning, light yellow
// [RULE10] Both supply voltages readable separately
// [RULE11] Supply out of range: error, status, event
// [RULE12] No system pressure given: assume optimum
// [RULE13] Warnings and errors sent as events
// [RULE14] Cycle start clears leakage and quality averages
// [RULE15] Quality percent falls as leakage rises
// [RULE16] Performance zero on high or null pressure
// [RULE17] Warning bits 0..4 fixed, rest reserved
// [RULE18] Sliding 3 s window catches seven switchings
`ifndef VCM_DEFS_SVH
`define VCM_DEFS_SVH
`define IDX_SENSOR_SUPPLY 16'h0042
`define IDX_ACTUATOR_SUPPLY 16'h0043
`define IDX_LEAK_LIMIT 16'h006C
`define IDX_LEAK_FLOW 16'h00A0
`define IDX_QUALITY 16'h00A2
`define IDX_PERFORMANCE 16'h00A3
`define CM_VALVE 0
`define CM_EVAC 1
`define CM_LEAK 2
`define CM_SWITCH 3
`define CM_DYN 4
`define LEAK_LIMIT_RST 16'h0000
`define LEAK_LIMIT_MAX 16'h270F
`define CLK_NS 32'h32
`define MS_NS 32'hF4240
`define SW_WIN_MS 12'hBB8
`define AGE_SAT 12'hFFF
`define DYN_SAMPLE_MS 8'h14
`define SUP_MIN_MV 16'h4FB0
`define SUP_MAX_MV 16'h6BD0
`define OPT_PRESSURE 16'h1770
`define AVG_SHIFT 3
`define QUAL_SHIFT 6
`define PERF_SHIFT 3
`define PCT_FULL 8'h64
`endif

// [rtl/vcm_pkg.sv]
// Types shared by the vacuum condition monitor.
// Pressures in mbar, unsigned 16 bit.
package vcm_pkg;
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_SUCK = 3'b010, ST_HOLD = 3'b100} state_e;
  typedef enum logic [2:0] {LT_GREEN = 3'b001, LT_YELLOW = 3'b010, LT_RED = 3'b100} light_e;
  typedef struct packed {
    logic [15:0] vacuum_switch_threshold;
    logic [15:0] vacuum_reset_threshold;
    logic [15:0] part_present_on_threshold;
    logic [15:0] part_present_off_threshold;
  } thr_s;
endpackage

// [rtl/vacuum_condition_monitor.sv]
// Condition monitor of one vacuum component: valve guard, leakage, ratings, supplies.
// Inputs come from logic on clk_sys (ADC, IO-Link stack); none need synchronising.
`timescale 1ns/10ps
`include "vcm_defs.svh"
module vacuum_condition_monitor #(
  parameter int CYC_PER_MS = `MS_NS / `CLK_NS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Suction control and measurements
  input wire logic suction_on,
  input wire logic air_save_en,
  input wire logic control_mode,
  input wire logic [15:0] vacuum_mbar,
  input wire vcm_pkg::thr_s thr,
  input wire logic [15:0] evacuation_interval,
  input wire logic [15:0] sys_pressure,
  input wire logic sys_pressure_valid,
  input wire logic [15:0] sensor_supply,
  input wire logic [15:0] actuator_supply,
  // Parameter access from the IO-Link stack
  input wire logic [15:0] param_index,
  input wire logic param_wr,
  input wire logic [15:0] param_wdata,
  output logic [15:0] param_rdata,
  // Status
  output logic pilot_valve,
  output logic [15:0] cm_word,
  output logic device_error,
  output vcm_pkg::light_e status_light,
  output logic event_valid,
  output logic [2:0] event_code
);
  import vcm_pkg::*;

  function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
    sat_sub = (a > b) ? 16'(a - b) : 16'h0000;
  endfunction

  state_e state_q;
  light_e light_q;
  logic [14:0] ms_cnt_q;
  logic tick, suction_q, start, stop, valve_q, toggle, trip, prot_q;
  logic [11:0] age_q [0:5];
  logic [4:0] cm_q;
  logic sw_seen_q, pp_seen_q, evac_run_q, dyn_done_q, err_q, err_in;
  logic [15:0] evac_ms_q, dyn_q, leak_q, last_vac_q, limit_q, eff_p, drop, leak_smp;
  logic [7:0] dyn_ms_q, qual_q, perf_q, q_inst;
  logic [31:0] leak_prod;
  logic [16:0] leak_step;
  logic [8:0] qual_step;
  logic [5:0] flags_q, pend_q, sent;
  logic [2:0] pick;
  logic pick_ok;

  // Millisecond time base
  assign tick = (ms_cnt_q == 15'(CYC_PER_MS - 1));
  always_ff @(posedge clk_sys)
  begin
    if (rst || tick)
      ms_cnt_q <= 15'h0000;
    else
      ms_cnt_q <= 15'(ms_cnt_q + 15'h0001);
  end

  // Suction command edges bound each cycle
  assign start = suction_on & ~suction_q;
  assign stop = ~suction_on & suction_q;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      suction_q <= 1'b0;
    else
      suction_q <= suction_on;
  end

  // Suction control; air saving stops once protection has tripped
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      state_q <= ST_IDLE;
    else
    begin
      case (state_q)
        ST_IDLE:
          if (start)
            state_q <= ST_SUCK;
        ST_SUCK:
          if (!suction_on)
            state_q <= ST_IDLE;
          else if (air_save_en && !prot_q && vacuum_mbar >= thr.vacuum_switch_threshold)
            state_q <= ST_HOLD; // [RULE1]
        ST_HOLD:
          if (!suction_on)
            state_q <= ST_IDLE;
          else if (prot_q || vacuum_mbar <= thr.vacuum_reset_threshold)
            state_q <= ST_SUCK; // [RULE1] [RULE5]
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end
  assign pilot_valve = (state_q == ST_SUCK);

  // Switching history: age in ms of the last six valve transitions
  assign toggle = pilot_valve ^ valve_q;
  assign trip = toggle && (age_q[5] < `SW_WIN_MS); // [RULE18]
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      valve_q <= 1'b0;
    else
      valve_q <= pilot_valve;
  end
  for (genvar i = 0; i < 6; i++)
  begin : g_age
    always_ff @(posedge clk_sys)
    begin
      if (rst)
        age_q[i] <= `AGE_SAT;
      else if (toggle)
        age_q[i] <= (i == 0) ? 12'h000 : age_q[(i == 0) ? 0 : i - 1]; // [RULE18]
      else if (tick && age_q[i] != `AGE_SAT)
        age_q[i] <= 12'(age_q[i] + 12'h001);
    end
  end

  // Protection stays latched until reset: suction must not pulse again
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      prot_q <= 1'b0;
    else if (trip)
      prot_q <= 1'b1; // [RULE1]
  end

  // Evacuation timing from part-present to switch threshold; cleared at stop too,
  // so a timer left running in idle cannot re-arm the warning as the next cycle starts
  always_ff @(posedge clk_sys)
  begin
    if (rst || start || stop)
    begin
      sw_seen_q <= 1'b0;
      pp_seen_q <= 1'b0;
      evac_run_q <= 1'b0;
      evac_ms_q <= 16'h0000;
    end
    else if (state_q != ST_IDLE)
    begin
      if (vacuum_mbar >= thr.vacuum_switch_threshold)
      begin
        sw_seen_q <= 1'b1;
        evac_run_q <= 1'b0;
      end
      else if (!pp_seen_q && vacuum_mbar >= thr.part_present_on_threshold)
      begin
        pp_seen_q <= 1'b1;
        evac_run_q <= 1'b1; // [RULE3]
      end
      if (evac_run_q && tick && evac_ms_q != 16'hFFFF)
        evac_ms_q <= 16'(evac_ms_q + 16'h0001);
    end
  end

  // Dynamic pressure taken early in the cycle while still below switch point
  always_ff @(posedge clk_sys)
  begin
    if (rst || start)
    begin
      dyn_ms_q <= 8'h00;
      dyn_done_q <= 1'b0;
      dyn_q <= 16'h0000;
    end
    else if (state_q != ST_IDLE && !dyn_done_q)
    begin
      if (tick)
        dyn_ms_q <= 8'(dyn_ms_q + 8'h01);
      if (dyn_ms_q == `DYN_SAMPLE_MS)
      begin
        dyn_done_q <= 1'b1;
        if (!sw_seen_q)
          dyn_q <= vacuum_mbar; // [RULE8]
      end
    end
  end

  // Leakage from vacuum decay while the valve rests, scaled by system pressure
  assign eff_p = sys_pressure_valid ? sys_pressure : `OPT_PRESSURE; // [RULE12]
  assign drop = sat_sub(last_vac_q, vacuum_mbar);
  assign leak_prod = drop * eff_p;
  assign leak_smp = (|leak_prod[31:24]) ? 16'hFFFF : leak_prod[23:8];
  assign leak_step = 17'($signed({1'b0, leak_smp} - {1'b0, leak_q}) >>> `AVG_SHIFT);
  assign q_inst = (leak_q[15:`QUAL_SHIFT] >= 10'(`PCT_FULL)) ? 8'h00
    : 8'(`PCT_FULL - 8'(leak_q[15:`QUAL_SHIFT])); // [RULE15]
  assign qual_step = 9'($signed({1'b0, q_inst} - {1'b0, qual_q}) >>> `AVG_SHIFT);
  always_ff @(posedge clk_sys)
  begin
    if (rst || start)
    begin
      leak_q <= 16'h0000; // [RULE14]
      qual_q <= 8'h00;
      last_vac_q <= vacuum_mbar;
    end
    else if (tick)
    begin
      last_vac_q <= vacuum_mbar;
      if (state_q == ST_HOLD && control_mode)
      begin
        leak_q <= 16'({1'b0, leak_q} + leak_step); // [RULE4] [RULE14]
        qual_q <= 8'({1'b0, qual_q} + qual_step); // [RULE15]
      end
    end
  end

  // Performance fixed when suction ends; a missing sample reads as zero
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      perf_q <= 8'h00;
    else if (stop)
    begin
      if (dyn_q == 16'h0000 || dyn_q > thr.part_present_on_threshold)
        perf_q <= 8'h00; // [RULE16]
      else if (dyn_q[15:`PERF_SHIFT] >= 13'(`PCT_FULL))
        perf_q <= 8'h00;
      else
        perf_q <= 8'(`PCT_FULL - 8'(dyn_q[15:`PERF_SHIFT]));
    end
  end

  // Warning bits 1..4 cleared only as a new cycle starts, so no set is lost; bit 0 follows the protection latch
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cm_q <= 5'h00;
    else
    begin
      if (start)
        cm_q[4:1] <= 4'h0;
      cm_q[`CM_VALVE] <= prot_q | trip; // [RULE2] [RULE17]
      if (evac_run_q && evac_ms_q > evacuation_interval)
        cm_q[`CM_EVAC] <= 1'b1; // [RULE3]
      if (tick && state_q == ST_HOLD && control_mode && limit_q != 16'h0000 && leak_q > limit_q)
        cm_q[`CM_LEAK] <= 1'b1; // [RULE6] [RULE7]
      if (stop && !sw_seen_q)
        cm_q[`CM_SWITCH] <= 1'b1;
      if (!dyn_done_q && state_q != ST_IDLE && dyn_ms_q == `DYN_SAMPLE_MS && !sw_seen_q
          && vacuum_mbar > sat_sub(thr.part_present_on_threshold, thr.part_present_off_threshold)
          && vacuum_mbar < thr.vacuum_switch_threshold)
        cm_q[`CM_DYN] <= 1'b1; // [RULE9]
    end
  end
  assign cm_word = {11'h000, cm_q}; // [RULE17]

  // Supply supervision and status light
  assign err_in = sensor_supply < `SUP_MIN_MV || sensor_supply > `SUP_MAX_MV
    || actuator_supply < `SUP_MIN_MV || actuator_supply > `SUP_MAX_MV;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      err_q <= 1'b0;
      light_q <= LT_GREEN;
    end
    else
    begin
      err_q <= err_in; // [RULE11]
      light_q <= err_q ? LT_RED : (|cm_q ? LT_YELLOW : LT_GREEN); // [RULE3] [RULE6] [RULE9] [RULE11]
    end
  end
  assign device_error = err_q;
  assign status_light = light_q;

  // Event queue: each rising flag waits until sent, lowest bit first
  always_comb
  begin
    pick = 3'h0;
    pick_ok = 1'b0;
    for (int k = 5; k >= 0; k--)
      if (pend_q[k])
      begin
        pick = 3'(k);
        pick_ok = 1'b1;
      end
  end
  assign sent = pick_ok ? (6'h01 << pick) : 6'h00;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      flags_q <= 6'h00;
      pend_q <= 6'h00;
      event_valid <= 1'b0;
      event_code <= 3'h0;
    end
    else
    begin
      flags_q <= {err_q, cm_q};
      pend_q <= (pend_q & ~sent) | ({err_q, cm_q} & ~flags_q); // [RULE13]
      event_valid <= pick_ok;
      event_code <= pick;
    end
  end

  // Parameter access; out-of-range limits are ignored
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      limit_q <= `LEAK_LIMIT_RST;
    else if (param_wr && param_index == `IDX_LEAK_LIMIT && param_wdata <= `LEAK_LIMIT_MAX)
      limit_q <= param_wdata; // [RULE7]
  end
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      param_rdata <= 16'h0000;
    else
    begin
      case (param_index)
        `IDX_SENSOR_SUPPLY: param_rdata <= sensor_supply; // [RULE10]
        `IDX_ACTUATOR_SUPPLY: param_rdata <= actuator_supply; // [RULE10]
        `IDX_LEAK_LIMIT: param_rdata <= limit_q;
        `IDX_LEAK_FLOW: param_rdata <= leak_q; // [RULE4]
        `IDX_QUALITY: param_rdata <= {8'h00, qual_q};
        `IDX_PERFORMANCE: param_rdata <= {8'h00, perf_q};
        default: param_rdata <= 16'h0000;
      endcase
    end
  end

  // Checks
  valve_trip_a: assert property (@(posedge clk_sys) disable iff (rst) trip |=> prot_q && cm_q[0]) // [RULE1]
    else $error("valve protection not latched");
  no_saving_a: assert property (@(posedge clk_sys) disable iff (rst) prot_q && $past(prot_q) |-> state_q != ST_HOLD) // [RULE1]
    else $error("air saving after protection");
  prot_bit_a: assert property (@(posedge clk_sys) disable iff (rst) $rose(prot_q) |-> cm_word[0]) // [RULE2]
    else $error("protection bit missing");
  evac_warn_a: assert property (@(posedge clk_sys) disable iff (rst)
    evac_run_q && evac_ms_q > evacuation_interval |=> cm_q[1] ##1 light_q != LT_GREEN) // [RULE3]
    else $error("evacuation warning missing");
  leak_zero_a: assert property (@(posedge clk_sys) disable iff (rst) limit_q == 16'h0000 |=> !$rose(cm_q[2])) // [RULE7]
    else $error("leak warning with zero limit");
  limit_range_a: assert property (@(posedge clk_sys) disable iff (rst) limit_q <= `LEAK_LIMIT_MAX) // [RULE7]
    else $error("leak limit out of range");
  cycle_clear_a: assert property (@(posedge clk_sys) disable iff (rst) start |=> leak_q == 16'h0000 && qual_q == 8'h00) // [RULE14]
    else $error("cycle start did not clear averages");
  perf_zero_a: assert property (@(posedge clk_sys) disable iff (rst) stop && dyn_q == 16'h0000 |=> perf_q == 8'h00) // [RULE16]
    else $error("performance not zero");
  supply_err_a: assert property (@(posedge clk_sys) disable iff (rst) err_in |=> device_error ##1 light_q == LT_RED) // [RULE11]
    else $error("supply error not shown");
  event_out_a: assert property (@(posedge clk_sys) disable iff (rst) $rose(err_q) |-> ##[1:7] event_valid) // [RULE13]
    else $error("event not sent");
  trip_c: cover property (@(posedge clk_sys) disable iff (rst) trip);
  hold_c: cover property (@(posedge clk_sys) disable iff (rst) state_q == ST_HOLD ##1 state_q == ST_SUCK);
  leak_c: cover property (@(posedge clk_sys) disable iff (rst) $rose(cm_q[2]));
  event_c: cover property (@(posedge clk_sys) disable iff (rst) event_valid && event_code == 3'h5);
endmodule

// [sim/iolink_master_model.sv]
// Stand-in for the IO-Link master: parameter access and system pressure process data.
// Assumes the device samples these lines on the rising edge of clk_sys.
`timescale 1ns/10ps
module iolink_master_model (
  // Clock
  input wire logic clk_sys,
  // Parameter channel
  output logic [15:0] param_index,
  output logic param_wr,
  output logic [15:0] param_wdata,
  input wire logic [15:0] param_rdata,
  // Process data
  output logic [15:0] sys_pressure,
  output logic sys_pressure_valid
);
  // Idle master: no write, no pressure offered
  initial
  begin
    param_index = 16'h0000;
    param_wr = 1'b0;
    param_wdata = 16'h0000;
    sys_pressure = 16'h0000;
    sys_pressure_valid = 1'b0;
  end
  // One write held a full cycle; data scrambled once the strobe drops
  task automatic param_write(input logic [15:0] idx, input logic [15:0] val);
    @(negedge clk_sys);
    param_index = idx;
    param_wdata = val;
    param_wr = 1'b1;
    @(negedge clk_sys);
    param_wr = 1'b0;
    param_wdata = ~val;
  endtask
  // Registered answer, so the data is taken one cycle after the index
  task automatic param_read(input logic [15:0] idx, output logic [15:0] val);
    @(negedge clk_sys);
    param_index = idx;
    @(negedge clk_sys);
    val = param_rdata;
  endtask
  // Invalid pressure carries junk so the device cannot lean on it
  task automatic set_pressure(input logic ok, input logic [15:0] p);
    @(negedge clk_sys);
    sys_pressure_valid = ok;
    sys_pressure = ok ? p : ~p;
  endtask
endmodule

// [sim/tb_vacuum_condition_monitor.sv]
// Self-checking bench of the vacuum condition monitor against integer expectations.
// Assumes CYC_PER_MS=20, so one ms is 20 clocks of 50 ns.
`timescale 1ns/10ps
module tb_vacuum_condition_monitor;
  import vcm_pkg::*;
  logic clk_sys, rst, suction_on, air_save_en, control_mode;
  logic [15:0] vacuum_mbar, evacuation_interval, sensor_supply, actuator_supply;
  logic [15:0] param_index, param_wdata, param_rdata, sys_pressure, cm_word, rd;
  logic param_wr, sys_pressure_valid, pilot_valve, device_error, event_valid;
  logic [2:0] event_code;
  light_e status_light;
  thr_s thr;
  int fails, samples_checked, i, k, v, seed;
  int vt[3] = '{200, 450, 0};
  vacuum_condition_monitor #(.CYC_PER_MS(20)) DUT (.clk_sys(clk_sys), .rst(rst), .suction_on(suction_on),
    .air_save_en(air_save_en), .control_mode(control_mode), .vacuum_mbar(vacuum_mbar), .thr(thr),
    .evacuation_interval(evacuation_interval), .sys_pressure(sys_pressure), .sys_pressure_valid(sys_pressure_valid),
    .sensor_supply(sensor_supply), .actuator_supply(actuator_supply), .param_index(param_index),
    .param_wr(param_wr), .param_wdata(param_wdata), .param_rdata(param_rdata), .pilot_valve(pilot_valve),
    .cm_word(cm_word), .device_error(device_error), .status_light(status_light), .event_valid(event_valid),
    .event_code(event_code));
  iolink_master_model mst (.clk_sys(clk_sys), .param_index(param_index), .param_wr(param_wr),
    .param_wdata(param_wdata), .param_rdata(param_rdata), .sys_pressure(sys_pressure),
    .sys_pressure_valid(sys_pressure_valid));
  // 20 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  function automatic int rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed & 32'h7FFFFFFF;
  endfunction
  // Expected performance: null or too-high dynamic pressure rates zero
  function automatic int perf(input int d);
    if (d == 0 || d > 400)
      return 0;
    return (d >> 3) > 100 ? 0 : 100 - (d >> 3);
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("Counts: %0d checked, %0d mismatches", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wait_ms(input int n);
    repeat (n * 20) @(negedge clk_sys);
  endtask
  // Bounded wait for a valve level or one event code
  task automatic wait_for(input bit valve, input logic [2:0] code);
    logic seen;
    seen = 1'b0;
    for (k = 0; k < 60 && !seen; k++)
    begin
      @(posedge clk_sys);
      #1;
      seen = valve ? (pilot_valve === code[0]) : (event_valid === 1'b1 && event_code === code);
    end
    check({15'h0, seen}, 16'h0001);
    if (!seen)
      close_out();
  endtask
  task automatic rd_chk(input logic [15:0] idx, input logic [15:0] exp);
    mst.param_read(idx, rd);
    check(rd, exp);
  endtask
  task automatic do_reset();
    @(negedge clk_sys);
    rst = 1'b1;
    suction_on = 1'b0;
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
  endtask
  initial
  begin
    seed = 23;
    fails = 0;
    samples_checked = 0;
    rst = 1'b1;
    suction_on = 1'b0;
    air_save_en = 1'b0;
    control_mode = 1'b0;
    vacuum_mbar = 16'h0000;
    evacuation_interval = 16'h0002;
    sensor_supply = 16'h5DC0;
    actuator_supply = 16'h5DC0;
    thr = '{16'h0258, 16'h01F4, 16'h0190, 16'h0032};
    do_reset();
    // Reset values, limit writes at the upper edge of the range, supply readback
    check(cm_word, 16'h0000);
    check({13'h0, status_light}, {13'h0, LT_GREEN});
    rd_chk(16'h006C, 16'h0000);
    mst.param_write(16'h006C, 16'h0005);
    rd_chk(16'h006C, 16'h0005);
    mst.param_write(16'h006C, 16'h2710);
    rd_chk(16'h006C, 16'h0005);
    mst.param_write(16'h006C, 16'h270F);
    rd_chk(16'h006C, 16'h270F);
    for (i = 0; i < 4; i++)
    begin
      sensor_supply = 16'(20400 + rnd() % 7201);
      actuator_supply = 16'(20400 + rnd() % 7201);
      rd_chk(16'h0042, sensor_supply);
      rd_chk(16'h0043, actuator_supply);
    end
    $display("test params done");
    // Dynamic pressure below, inside and null; switch point never reached
    for (i = 0; i < 3; i++)
    begin
      do_reset();
      v = vt[i];
      vacuum_mbar = 16'(v);
      suction_on = 1'b1;
      wait_for(1'b1, 3'h1);
      wait_ms(25);
      check({15'h0, cm_word[4]}, {15'h0, v > 350 && v < 600});
      suction_on = 1'b0;
      wait_for(1'b0, 3'h3);
      check(cm_word, {11'h0, v > 350 && v < 600, 2'b10, v >= 400, 1'b0});
      check({13'h0, status_light}, {13'h0, LT_YELLOW});
      rd_chk(16'h00A3, 16'(perf(v)));
    end
    $display("test dynamic pressure done");
    // Leakage in hold, warned limit then disabled limit, given and assumed pressure
    for (i = 0; i < 2; i++)
    begin
      do_reset();
      mst.param_write(16'h006C, i ? 16'h0000 : 16'h0005);
      mst.set_pressure(i == 0, 16'hFFFF);
      air_save_en = 1'b1;
      control_mode = 1'b1;
      vacuum_mbar = 16'h01C2;
      suction_on = 1'b1;
      wait_ms(5);
      vacuum_mbar = 16'h02BC;
      wait_for(1'b1, 3'h0);
      for (v = 700; v > 540; v -= 4)
      begin
        wait_ms(1);
        vacuum_mbar = 16'(v);
      end
      check(cm_word & 16'hFFF7, {13'h0, i == 0, 2'b10});
      check({13'h0, status_light}, {13'h0, LT_YELLOW});
      vacuum_mbar = 16'h01EA;
      wait_for(1'b1, 3'h1);
      wait_ms(1);
      suction_on = 1'b0;
      wait_ms(1);
      mst.param_read(16'h00A0, rd);
      check({15'h0, rd > 16'h003F}, 16'h0001);
      mst.param_read(16'h00A2, rd);
      check({15'h0, rd < 16'h0064}, 16'h0001);
      suction_on = 1'b1;
      rd_chk(16'h00A0, 16'h0000);
      suction_on = 1'b0;
    end
    $display("test leakage done");
    // Seven valve transitions inside the window trip the protection
    do_reset();
    evacuation_interval = 16'h0064;
    vacuum_mbar = 16'h01EA;
    suction_on = 1'b1;
    for (i = 1; i <= 8; i++)
    begin
      wait_ms(2);
      vacuum_mbar = i % 2 ? 16'h02BC : 16'h01EA;
      wait_ms(2);
      check({15'h0, cm_word[0]}, {15'h0, i >= 6});
      check({15'h0, pilot_valve}, {15'h0, i >= 6 || i % 2 == 0});
    end
    check({13'h0, status_light}, {13'h0, LT_YELLOW});
    suction_on = 1'b0;
    wait_ms(1);
    check({15'h0, cm_word[0]}, 16'h0001);
    $display("test protection done");
    // Supplies at the range edges and one step outside
    for (i = 0; i < 3; i++)
    begin
      do_reset();
      sensor_supply = i == 1 ? 16'h4FAF : 16'h4FB0;
      actuator_supply = i == 2 ? 16'h6BD1 : 16'h6BD0;
      if (i > 0)
        wait_for(1'b0, 3'h5);
      else
        wait_ms(2);
      check({15'h0, device_error}, {15'h0, i > 0});
      check({13'h0, status_light}, i > 0 ? {13'h0, LT_RED} : {13'h0, LT_GREEN});
    end
    $display("test supplies done");
    close_out();
  end
endmodule
